// >>> verilog/pfcmsc_pkg.sv
// Package of constants and types for the PFC mode and switching control engine
package pfcmsc_pkg;

    // ==========================================================
    // Sense word format: ratio to reference current, Q2.10
    localparam int SENSE_W = 12;
    localparam logic [11:0] REF_ONE = 12'h400;
    // Start-up entry below 90% of nominal, exit at 100%
    localparam logic [11:0] STARTUP_ENTER_LVL = 12'h39A;
    localparam logic [11:0] STARTUP_EXIT_LVL = 12'h400;
    // Overvoltage trip at 105% of reference
    localparam logic [11:0] OV_TRIP_LVL = 12'h433;
    // Overvoltage hysteresis, about 1% of reference
    localparam logic [11:0] OV_HYST_LVL = 12'h00A;
    // Line word below which switching stops near zero crossing
    localparam logic [11:0] LINE_ZERO_LVL = 12'h010;

    // ==========================================================
    // Timing at 250 MHz
    localparam int CLK_MHZ = 250;
    localparam int FSW_MAX_KHZ = 70;
    // Least period: 70 kHz ceiling, rounded up to whole cycles
    localparam int PERIOD_MIN_CYC = (CLK_MHZ * 1000 + FSW_MAX_KHZ - 1) / FSW_MAX_KHZ;
    // Longest period: twice the least, for the 2:1 swing
    localparam int PERIOD_MAX_CYC = 2 * PERIOD_MIN_CYC;
    // On-time limit 0.001126 V*s; volts per sense unit of the line word
    localparam int TON_VS_NANO = 1126000;
    localparam int VOLT_PER_REF = 400;
    // Cycles*ratio product: Ton(cycles) <= TON_K / line_word
    localparam longint TON_K =
        (longint'(TON_VS_NANO) * CLK_MHZ * 1024) / (longint'(VOLT_PER_REF) * 1000);
    // Start-up on-time cap, half the least period
    localparam int TON_STARTUP_CYC = PERIOD_MIN_CYC / 2;
    localparam int CNT_W = 16;

    // ==========================================================
    typedef enum logic [1:0] {PFCMSC_LINE_EVAL, PFCMSC_STARTUP, PFCMSC_NORMAL} pfcmsc_mode_t;

    typedef struct packed {
        logic [11:0] link;
        logic [11:0] line;
        logic        valid;
    } pfcmsc_sense_t;

    typedef struct packed {
        logic        gate;
        logic        startup;
        logic        ov_trip;
        logic        burst_idle;
    } pfcmsc_out_t;

endpackage : pfcmsc_pkg

// >>> verilog/pfcmsc_core.sv
// PFC mode selection, switching cycle shaping and overvoltage shutdown
`timescale 1ns/10ps

// Operation
// - Always exactly one of line evaluation, start-up or normal mode
// - Enter start-up at power-up, below 90%
// - Leave start-up at 100% nominal
// - Start-up caps on-time, squares current envelope
// - Evaluate line voltage before switching starts
// - Recompute period and on-time every cycle
// - Fastest at peak, slowest or stopped near zero
// - Frequency swings about two to one
// - Frequency never above 70 kHz
// - On-time at most 0.001126 over line voltage
// - Below 5% load, skip whole half-lines
// - Overvoltage kills gate immediately, bypassing loop
// - Resume below threshold minus hysteresis
// - Decisions use reference-ratio sense words
// - Overvoltage when link above 105% reference
module pfcmsc_core #(
    parameter int DEMAND_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire pfcmsc_pkg::pfcmsc_sense_t i_sense,
    input wire logic [DEMAND_W-1:0] i_demand,
    input wire logic [DEMAND_W-1:0] i_burst_level,
    output logic o_gate_drive_out,
    output logic o_startup_mode,
    output logic o_ov_trip,
    output logic o_burst_idle
);
    import pfcmsc_pkg::*;

    typedef struct packed {
        pfcmsc_mode_t mode;
        logic         ov;
        logic         burst;
        logic         line_hi;
        logic         gate;
        logic         cut;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] ton;
        logic [11:0]  line_pk;
        logic [11:0]  link;
        logic [11:0]  line;
    } pfcmsc_state_t;

    pfcmsc_state_t s_q;
    pfcmsc_state_t s_d;
    logic [1:0] rst_sync_q;
    logic rstn;

    // ==========================================================
    // Reset release
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rstn = rst_sync_q[1];

    // ==========================================================
    // Cycle shaping helpers
    // Period falls linearly from max at zero line to min at line peak
    function automatic logic [CNT_W-1:0] calc_period(input logic [11:0] line,
                                                     input logic [11:0] pk);
        logic [CNT_W+11:0] span;
        logic [CNT_W-1:0] red;
        span = '0;
        red = '0;
        span = (CNT_W+12)'(PERIOD_MAX_CYC - PERIOD_MIN_CYC) * (CNT_W+12)'(line);
        red = (pk == 12'h000) ? '0 : CNT_W'(span / (CNT_W+12)'(pk));
        if (red > CNT_W'(PERIOD_MAX_CYC - PERIOD_MIN_CYC)) begin
            red = CNT_W'(PERIOD_MAX_CYC - PERIOD_MIN_CYC);
        end
        calc_period = CNT_W'(PERIOD_MAX_CYC) - red;
    endfunction : calc_period

    function automatic logic [CNT_W-1:0] ton_limit(input logic [11:0] line);
        longint lim;
        lim = (line == 12'h000) ? longint'(PERIOD_MAX_CYC) : TON_K / longint'(line);
        if (lim > longint'(PERIOD_MAX_CYC)) begin
            lim = longint'(PERIOD_MAX_CYC);
        end
        ton_limit = CNT_W'(lim);
    endfunction : ton_limit

    // ==========================================================
    // Next-state logic
    logic ov_set;
    logic ov_clr;
    logic cyc_end;
    logic zero_x;
    logic sup;
    logic [CNT_W-1:0] per_n;
    logic [CNT_W-1:0] ton_n;
    logic [CNT_W+DEMAND_W-1:0] ton_dem;

    always_comb begin
        s_d = s_q;
        // Link is compared as a ratio of reference current
        // Words between conversions are not samples, so only valid ones count
        ov_set = i_sense.valid && (i_sense.link > OV_TRIP_LVL);
        ov_clr = i_sense.valid && (i_sense.link < (OV_TRIP_LVL - OV_HYST_LVL));
        cyc_end = (s_q.cnt >= s_q.period - CNT_W'(1));
        zero_x = s_q.line < LINE_ZERO_LVL;
        per_n = calc_period(s_q.line, s_q.line_pk);
        ton_dem = (CNT_W+DEMAND_W)'(per_n) * (CNT_W+DEMAND_W)'(i_demand);
        ton_n = CNT_W'(ton_dem >> DEMAND_W);
        if (ton_n > ton_limit(s_q.line)) begin
            ton_n = ton_limit(s_q.line);
        end
        if (i_sense.valid) begin
            s_d.link = i_sense.link;
            s_d.line = i_sense.line;
            if (i_sense.line > s_q.line_pk) begin
                s_d.line_pk = i_sense.line;
            end
        end
        if (ov_set) begin
            s_d.ov = 1'b1;
        end else if (ov_clr) begin
            s_d.ov = 1'b0;
        end
        case (s_q.mode)
            PFCMSC_LINE_EVAL: begin
                // Wait until the line has been at or above LINE_ZERO_LVL and falls back below it, to learn the line peak first
                if (i_sense.valid && s_q.line_hi && i_sense.line < LINE_ZERO_LVL) begin
                    s_d.mode = PFCMSC_STARTUP;
                end
            end
            PFCMSC_STARTUP: begin
                if (s_q.link >= STARTUP_EXIT_LVL) begin
                    s_d.mode = PFCMSC_NORMAL;
                end
                if (ton_n > CNT_W'(TON_STARTUP_CYC)) begin
                    ton_n = CNT_W'(TON_STARTUP_CYC);
                end
                per_n = CNT_W'(PERIOD_MIN_CYC);
            end
            PFCMSC_NORMAL: begin
                if (s_q.link < STARTUP_ENTER_LVL) begin
                    s_d.mode = PFCMSC_STARTUP;
                end
            end
            default: begin
                s_d.mode = PFCMSC_STARTUP;
            end
        endcase
        if (i_sense.valid) begin
            s_d.line_hi = i_sense.line >= LINE_ZERO_LVL;
            // Burst decision taken once per half-line, at its start
            if (!s_q.line_hi && i_sense.line >= LINE_ZERO_LVL) begin
                s_d.burst = (s_q.mode == PFCMSC_NORMAL) && (i_demand < i_burst_level)
                            && !s_q.burst;
            end
        end
        s_d.cnt = cyc_end ? '0 : s_q.cnt + CNT_W'(1);
        if (cyc_end) begin
            s_d.period = per_n;
            s_d.ton = ton_n;
        end
        // Cap the running window too, so entering start-up never stretches a pulse
        if (s_d.mode == PFCMSC_STARTUP && s_d.ton > CNT_W'(TON_STARTUP_CYC)) begin
            s_d.ton = CNT_W'(TON_STARTUP_CYC);
        end
        // Overvoltage is checked on the raw input for a same-cycle cut
        sup = (s_q.mode == PFCMSC_LINE_EVAL) || ov_set || s_q.ov || s_q.burst || zero_x;
        // A window cut by suppression stays off until the next cycle starts,
        // so one period never carries two pulses
        s_d.cut = (!cyc_end && s_q.cut) || sup;
        s_d.gate = !s_d.cut && (s_d.cnt < s_d.ton);
    end

    always_ff @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{mode: PFCMSC_LINE_EVAL, period: CNT_W'(PERIOD_MAX_CYC), default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    always_ff @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            o_gate_drive_out <= 1'b0;
            o_startup_mode <= 1'b1;
            o_ov_trip <= 1'b0;
            o_burst_idle <= 1'b0;
        end else begin
            o_gate_drive_out <= s_d.gate;
            o_startup_mode <= s_d.mode != PFCMSC_NORMAL;
            o_ov_trip <= s_d.ov;
            o_burst_idle <= s_d.burst;
        end
    end

    // ==========================================================
    // Checks
    a_ov_gate_off: assert property (@(posedge i_clk) disable iff (!rstn)
        (i_sense.valid && i_sense.link > OV_TRIP_LVL) |=> !o_gate_drive_out)
        else $error("gate high after overvoltage sample");
    a_ov_hold: assert property (@(posedge i_clk) disable iff (!rstn)
        (s_q.ov && !(i_sense.valid && i_sense.link < (OV_TRIP_LVL - OV_HYST_LVL)))
        |=> s_q.ov)
        else $error("overvoltage released above hysteresis");
    a_ov_set: assert property (@(posedge i_clk) disable iff (!rstn)
        (i_sense.valid && i_sense.link > OV_TRIP_LVL) |=> o_ov_trip)
        else $error("overvoltage not flagged");
    a_burst_quiet: assert property (@(posedge i_clk) disable iff (!rstn)
        (o_burst_idle || o_ov_trip) |-> !o_gate_drive_out)
        else $error("gate high while suppressed");
    a_mode_valid: assert property (@(posedge i_clk) disable iff (!rstn)
        s_q.mode inside {PFCMSC_LINE_EVAL, PFCMSC_STARTUP, PFCMSC_NORMAL})
        else $error("illegal mode");
    a_enter_startup: assert property (@(posedge i_clk) disable iff (!rstn)
        (s_q.mode == PFCMSC_NORMAL && s_q.link < STARTUP_ENTER_LVL)
        |=> s_q.mode == PFCMSC_STARTUP)
        else $error("no start-up entry below 90 percent");
    a_exit_startup: assert property (@(posedge i_clk) disable iff (!rstn)
        (s_q.mode == PFCMSC_STARTUP && s_q.link < STARTUP_EXIT_LVL)
        |=> s_q.mode != PFCMSC_NORMAL)
        else $error("left start-up below 100 percent");
    a_period_range: assert property (@(posedge i_clk) disable iff (!rstn)
        s_q.period >= CNT_W'(PERIOD_MIN_CYC)
        && s_q.period <= CNT_W'(PERIOD_MAX_CYC))
        else $error("period out of range");
    a_ton_limit: assert property (@(posedge i_clk) disable iff (!rstn)
        s_q.cnt == '0 |-> s_q.ton <= ton_limit($past(s_q.line)))
        else $error("on-time beyond limit");
    a_eval_quiet: assert property (@(posedge i_clk) disable iff (!rstn)
        s_q.mode == PFCMSC_LINE_EVAL |=> !o_gate_drive_out)
        else $error("switching before line evaluated");
    a_zero_quiet: assert property (@(posedge i_clk) disable iff (!rstn)
        (s_q.line < LINE_ZERO_LVL) |=> !o_gate_drive_out)
        else $error("gate high near zero crossing");
    a_startup_cap: assert property (@(posedge i_clk) disable iff (!rstn)
        (s_q.mode == PFCMSC_STARTUP) |-> (s_q.ton <= CNT_W'(TON_STARTUP_CYC)))
        else $error("start-up on-time above cap");

endmodule : pfcmsc_core

// >>> verif/pfcmsc_stage_model.sv
// Boost stage and sense divider model feeding the sense words
`timescale 1ns/10ps
module pfcmsc_stage_model (
    input wire logic i_clk,
    input wire logic [11:0] i_link,
    output pfcmsc_pkg::pfcmsc_sense_t o_sense
);
    import pfcmsc_pkg::*;
    logic [12:0] phase_q = 13'h0000;
    logic [11:0] mag;
    // ==========================================================
    // Rectified line as a triangle, one half-line every 8192 cycles
    assign mag = phase_q[12] ? ~phase_q[11:0] : phase_q[11:0];
    initial o_sense = '0;
    // One conversion every fourth cycle; words between samples are junk
    always @(posedge i_clk) begin
        phase_q <= phase_q + 13'h0001;
        o_sense.valid <= (phase_q[1:0] == 2'h3);
        if (phase_q[1:0] == 2'h3) begin
            o_sense.link <= i_link;
            o_sense.line <= {3'h0, mag[11:3]};
        end else begin
            o_sense.link <= ~o_sense.link;
            o_sense.line <= ~o_sense.line;
        end
    end
endmodule : pfcmsc_stage_model

// >>> verif/testbench.sv
// Self-checking bench for the PFC mode and switching control engine
`timescale 1ns/10ps
module testbench;
    import pfcmsc_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [11:0] link = 12'h3C0;
    logic [7:0] demand = 8'h80;
    logic [7:0] blevel = 8'h10;
    pfcmsc_sense_t sense;
    logic gate, startup, ov, bidle;
    logic gate_p = 1'b0;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int per_cnt = 0;
    int hi_cnt = 0;
    int rises = 0;
    int n;
    int r;
    initial forever #2 i_clk = ~i_clk;
    pfcmsc_stage_model stage (.i_clk(i_clk), .i_link(link), .o_sense(sense));
    pfcmsc_core dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_sense(sense), .i_demand(demand),
        .i_burst_level(blevel), .o_gate_drive_out(gate), .o_startup_mode(startup),
        .o_ov_trip(ov), .o_burst_idle(bidle));
    // ==========================================================
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
    endtask : tick
    task print_verdict;
        $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // ==========================================================
    // Gate monitor: period floor, start-up on-time cap, suppression
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        gate_p <= gate;
        hi_cnt <= gate ? hi_cnt + 1 : 0;
        per_cnt <= (gate && !gate_p) ? 1 : per_cnt + 1;
        if (gate && !gate_p) begin
            rises <= rises + 1;
            if (rises > 0) check("period", 16'(per_cnt >= PERIOD_MIN_CYC), 16'h0001);
        end
        if (gate && startup) check("ton_cap", 16'(hi_cnt < TON_STARTUP_CYC), 16'h0001);
        if (gate) check("suppressed", {14'h0000, ov, bidle}, 16'h0000);
        if (cycles == 100000) begin
            miscompares++;
            print_verdict();
        end
    end
    // ==========================================================
    task t_reset;
        tick(4);
        check("reset_out", {12'h000, gate, startup, ov, bidle}, 16'h0004);
        i_rstn <= 1'b1;
    endtask : t_reset
    task t_startup;
        tick(8000);
        check("no_gate_eval", 16'(rises), 16'h0000);
        tick(8384);
        check("startup_hold", {15'h0000, startup}, 16'h0001);
        check("switching", 16'(rises > 0), 16'h0001);
        link <= 12'h400;
        for (n = 0; n < 16 && startup !== 1'b0; n++) tick(1);
        check("startup_exit", {15'h0000, startup}, 16'h0000);
    endtask : t_startup
    task t_band;
        link <= 12'h39A;
        tick(16);
        check("band_low_edge", {15'h0000, startup}, 16'h0000);
        link <= 12'h399;
        for (n = 0; n < 16 && startup !== 1'b1; n++) tick(1);
        check("startup_reenter", {15'h0000, startup}, 16'h0001);
        link <= 12'h400;
        for (n = 0; n < 16 && startup !== 1'b0; n++) tick(1);
        check("startup_exit2", {15'h0000, startup}, 16'h0000);
    endtask : t_band
    task t_ov;
        link <= 12'h433;
        tick(16);
        check("ov_at_trip", {15'h0000, ov}, 16'h0000);
        link <= 12'h434;
        for (n = 0; n < 16 && ov !== 1'b1; n++) tick(1);
        check("ov_trip_gate", {14'h0000, ov, gate}, 16'h0002);
        link <= 12'h429;
        tick(16);
        check("ov_hyst_hold", {15'h0000, ov}, 16'h0001);
        link <= 12'h428;
        for (n = 0; n < 16 && ov !== 1'b0; n++) tick(1);
        check("ov_resume", {15'h0000, ov}, 16'h0000);
        link <= 12'h400;
        r = rises;
        tick(16384);
        check("resume_switch", 16'(rises > r), 16'h0001);
    endtask : t_ov
    task t_burst;
        demand <= 8'h08;
        for (n = 0; n < 24576 && bidle !== 1'b1; n++) tick(1);
        check("burst_enter", {15'h0000, bidle}, 16'h0001);
        demand <= 8'h80;
        tick(16384);
        check("burst_leave", {15'h0000, bidle}, 16'h0000);
    endtask : t_burst
    initial begin
        t_reset();
        t_startup();
        t_band();
        t_ov();
        t_burst();
        print_verdict();
    end
endmodule : testbench
